// ### src/srm_defines.vh
/*
  Constants for the scan result match stage: register offsets, field positions,
  reset values, comparison function codes and link timing.
  Assumes a 50 MHz ref_clk.
*/
`ifndef SRM_DEFINES_VH
`define SRM_DEFINES_VH

// ----------------------------------------------------------------
// Register offsets (word index on the plain register port)
// ----------------------------------------------------------------
`define SRM_REG_CTRL      4'h0
`define SRM_REG_FUNC      4'h1
`define SRM_REG_STATUS    4'h2
`define SRM_REG_REF1      4'h3
`define SRM_REG_REF2      4'h4
`define SRM_REG_SUBLEN    4'h5

// ----------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------
`define SRM_CTRL_LEARN_EN   0
`define SRM_CTRL_STATIC     1
`define SRM_CTRL_REF2_ACT   2
`define SRM_CTRL_SUBST_EN   3
`define SRM_CTRL_STAT_EN    4
`define SRM_CTRL_RELOAD     5
`define SRM_CTRL_ENTER_RD   6
`define SRM_CTRL_RESET      8'h00
`define SRM_FUNC_RESET      12'h111

// ----------------------------------------------------------------
// Comparison functions, three bits each
// ----------------------------------------------------------------
`define SRM_FN_NOMATCH    3'h0
`define SRM_FN_MATCH1     3'h1
`define SRM_FN_MISMATCH1  3'h2
`define SRM_FN_MATCH2     3'h3
`define SRM_FN_MISMATCH2  3'h4
`define SRM_FN_EITHER     3'h5
`define SRM_FN_BOTH       3'h6

// ----------------------------------------------------------------
// Code storage and link
// ----------------------------------------------------------------
`define SRM_CODE_W        32
`define SRM_SUB_MAX       50
`define SRM_STATUS_SUBST  4'h7
`define SRM_CLK_HZ        50000000
`define SRM_BAUD          9600
`define SRM_BIT_CYC       (`SRM_CLK_HZ / `SRM_BAUD)
`define SRM_PULSE_CYC     16'h2710
`define SRM_TONE_CYC      16'h4e20
`define SRM_CHAR_CR       8'h0d

`endif

// ### src/srm_scan_result_match.v
/*
  Reading-result stage: learns the first reference code from the teach
  switch, compares decoded codes, drives two results and a beeper, and
  forwards substitute strings received on a 9600 8N1 terminal link to
  the host after the reading pulse ends.
  Assumes decoded codes arrive as a one-cycle strobe on ref_clk, the
  non-volatile store acknowledges writes itself, and the host side takes
  characters with a valid/ready pair.
*/
// Operation
// - Switch opens: enter learn, static starts interval
// - Learn read: beep, end interval, hold code
// - Switch closes after read: store permanently
// - Then compare every code, pulse result two
// - No read: close ends interval, keep config
// - Every new opening re-enters learn mode
// - Entering reading mode samples switch for compare
// - Switch open at power-up: compare off
// - Reading mode entry gives two tones
// - Each output picks one of seven functions
// - Second-code functions need second code active
// - Substitute string forwarded in result frame
// - Substitute content at most fifty characters
// - Status field seven when status enabled
// - Other diagnosis fields may be arbitrary
// - Carriage return closes string, next begins
// - Drop control characters except carriage return
// - No echo on the terminal link
// - Send substitute only after reading pulse ends
// - Link runs 9600 baud, 8N1
// - Temporary substitute mode ends on reload
`timescale 1ns/1ps
`include "srm_defines.vh"

module srm_scan_result_match (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        resetn,
  // Register port
  input  wire [3:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  // Teach switch pin, high when closed
  input  wire        teach_sw,
  // Decoder and reading pulse
  input  wire        code_valid,
  input  wire [31:0] code_data,
  input  wire        read_pulse,
  output reg         read_interval,
  // Non-volatile parameter write
  output reg         nv_write,
  output reg  [31:0] nv_data,
  // Result outputs and beeper
  output reg         result1,
  output reg         result2,
  output reg         beeper,
  // Terminal link, receive only
  input  wire        term_rxd,
  // Host frame output
  output reg         host_valid,
  output reg  [7:0]  host_data,
  output reg         host_last,
  output reg  [3:0]  host_status,
  input  wire        host_ready
);

  localparam [2:0]  ST_IDLE  = 3'h1;
  localparam [2:0]  ST_START = 3'h2;
  localparam [2:0]  ST_DATA  = 3'h4;
  localparam [31:0] BIT_W    = `SRM_BIT_CYC;
  localparam [31:0] GAP_W    = `SRM_TONE_CYC * 2;
  localparam [15:0] BIT_CYC  = BIT_W[15:0];
  localparam [15:0] HALF_CYC = BIT_W[16:1];
  localparam [15:0] GAP_CYC  = GAP_W[15:0];
  function fn_hit;
    input [2:0] fn;
    input       m1;
    input       m2;
    input       r2;
    begin
      case (fn)
        `SRM_FN_NOMATCH:   fn_hit = !m1 && !(m2 && r2);
        `SRM_FN_MATCH1:    fn_hit = m1;
        `SRM_FN_MISMATCH1: fn_hit = !m1;
        `SRM_FN_MATCH2:    fn_hit = r2 && m2;
        `SRM_FN_MISMATCH2: fn_hit = r2 && !m2;
        `SRM_FN_EITHER:    fn_hit = m1 || (r2 && m2);
        `SRM_FN_BOTH:      fn_hit = r2 && m1 && m2;
        default:           fn_hit = 1'b0;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg  [7:0]  ctrl_q;
  reg  [11:0] func_q;
  reg  [31:0] ref1_q;
  reg  [31:0] ref2_q;
  reg         cmp_en_q;
  reg         learn_q;
  reg         learned_q;
  reg  [31:0] learn_code_q;
  wire enter_rd = reg_wr && (reg_addr == `SRM_REG_CTRL) &&
                  reg_wdata[`SRM_CTRL_ENTER_RD];
  // ----------------------------------------------------------------
  // Switch synchroniser
  // ----------------------------------------------------------------
  reg [2:0] sw_sync_q;
  reg       sw_q;
  reg       boot_q;
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sw_sync_q <= 3'h0;
      sw_q      <= 1'b0;
    end else begin
      sw_sync_q <= {sw_sync_q[1:0], teach_sw};
      if (sw_sync_q[2] == sw_sync_q[1])
        sw_q <= sw_sync_q[2];
    end
  end
  wire sw_open_ev  = sw_q && !sw_sync_q[2] && !sw_sync_q[1] && !boot_q;
  wire sw_close_ev = !sw_q && sw_sync_q[2] && sw_sync_q[1] && !boot_q;
  // ----------------------------------------------------------------
  // Learn and compare control
  // ----------------------------------------------------------------
  reg [3:0] boot_cnt_q;
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_q        <= `SRM_CTRL_RESET;
      func_q        <= `SRM_FUNC_RESET;
      ref1_q        <= 32'h0;
      ref2_q        <= 32'h0;
      cmp_en_q      <= 1'b0;
      learn_q       <= 1'b0;
      learned_q     <= 1'b0;
      learn_code_q  <= 32'h0;
      read_interval <= 1'b0;
      nv_write      <= 1'b0;
      nv_data       <= 32'h0;
      boot_q        <= 1'b1;
      boot_cnt_q    <= 4'h0;
    end else begin
      nv_write <= 1'b0;
      if (reg_wr && reg_addr == `SRM_REG_CTRL)
        ctrl_q <= {1'b0, reg_wdata[6:0]} & 8'h1f;
      else if (reg_wr && reg_addr == `SRM_REG_FUNC)
        func_q <= reg_wdata[11:0];
      else if (reg_wr && reg_addr == `SRM_REG_REF1)
        ref1_q <= reg_wdata;
      else if (reg_wr && reg_addr == `SRM_REG_REF2)
        ref2_q <= reg_wdata;
      if (reg_wr && reg_addr == `SRM_REG_CTRL && reg_wdata[`SRM_CTRL_RELOAD])
        ctrl_q[`SRM_CTRL_SUBST_EN] <= 1'b0;
      // Boot waits for the synchroniser to settle before sampling.
      if (boot_q) begin
        boot_cnt_q <= boot_cnt_q + 4'h1;
        if (boot_cnt_q == 4'hf) begin
          boot_q <= 1'b0;
          cmp_en_q <= sw_q;
        end
      end else if (enter_rd) begin
        cmp_en_q <= sw_q;
        learn_q  <= 1'b0;
      end else if (ctrl_q[`SRM_CTRL_LEARN_EN] && sw_open_ev) begin
        learn_q       <= 1'b1;
        learned_q     <= 1'b0;
        read_interval <= ctrl_q[`SRM_CTRL_STATIC];
      end else if (learn_q && sw_close_ev) begin
        learn_q       <= 1'b0;
        read_interval <= 1'b0;
        if (learned_q) begin
          ref1_q   <= learn_code_q;
          nv_write <= 1'b1;
          nv_data  <= learn_code_q;
          cmp_en_q <= 1'b1;
        end
      end else if (learn_q && code_valid && !learned_q) begin
        learned_q     <= 1'b1;
        learn_code_q  <= code_data;
        read_interval <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Result pulses and beeper
  // ----------------------------------------------------------------
  reg [15:0] r1_cnt_q;
  reg [15:0] r2_cnt_q;
  reg [15:0] bp_cnt_q;
  reg [1:0]  tones_q;
  wire m1 = (code_data == ref1_q);
  wire m2 = (code_data == ref2_q);
  wire r2 = ctrl_q[`SRM_CTRL_REF2_ACT];
  wire cmp_ev = code_valid && cmp_en_q && !learn_q;
  wire learn_beep = learn_q && code_valid && !learned_q;
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      r1_cnt_q <= 16'h0;
      r2_cnt_q <= 16'h0;
      bp_cnt_q <= 16'h0;
      tones_q  <= 2'h0;
      result1  <= 1'b0;
      result2  <= 1'b0;
      beeper   <= 1'b0;
    end else begin
      if (cmp_ev && fn_hit(func_q[2:0], m1, m2, r2))
        r1_cnt_q <= `SRM_PULSE_CYC;
      else if (r1_cnt_q != 16'h0)
        r1_cnt_q <= r1_cnt_q - 16'h1;
      if (cmp_ev && fn_hit(func_q[6:4], m1, m2, r2))
        r2_cnt_q <= `SRM_PULSE_CYC;
      else if (r2_cnt_q != 16'h0)
        r2_cnt_q <= r2_cnt_q - 16'h1;
      if ((boot_q && boot_cnt_q == 4'hf) || enter_rd) begin
        tones_q  <= 2'h2;
        bp_cnt_q <= `SRM_TONE_CYC;
      end else if (learn_beep || (cmp_ev && fn_hit(func_q[10:8], m1, m2, r2))) begin
        tones_q  <= 2'h1;
        bp_cnt_q <= `SRM_TONE_CYC;
      end else if (bp_cnt_q != 16'h0) begin
        bp_cnt_q <= bp_cnt_q - 16'h1;
      end else if (tones_q != 2'h0) begin
        tones_q  <= tones_q - 2'h1;
        bp_cnt_q <= (tones_q == 2'h2) ? GAP_CYC : 16'h0;
      end
      result1 <= (r1_cnt_q != 16'h0);
      result2 <= (r2_cnt_q != 16'h0);
      beeper  <= (bp_cnt_q != 16'h0) && (tones_q != 2'h0) &&
                 !(tones_q == 2'h1 && bp_cnt_q > `SRM_TONE_CYC);
    end
  end

  // ----------------------------------------------------------------
  // Terminal receiver, 9600 8N1, no transmitter so nothing echoes
  // ----------------------------------------------------------------
  reg [2:0]  rx_sync_q;
  reg        rx_q;
  reg [2:0]  rx_st_q;
  reg [15:0] rx_cnt_q;
  reg [3:0]  rx_bit_q;
  reg [7:0]  rx_sh_q;
  reg        rx_done_q;
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rx_sync_q <= 3'h7;
      rx_q      <= 1'b1;
      rx_st_q   <= ST_IDLE;
      rx_cnt_q  <= 16'h0;
      rx_bit_q  <= 4'h0;
      rx_sh_q   <= 8'h0;
      rx_done_q <= 1'b0;
    end else begin
      rx_sync_q <= {rx_sync_q[1:0], term_rxd};
      if (rx_sync_q[2] == rx_sync_q[1])
        rx_q <= rx_sync_q[2];
      rx_done_q <= 1'b0;
      case (rx_st_q)
        ST_IDLE: begin
          if (!rx_q) begin
            rx_st_q  <= ST_START;
            rx_cnt_q <= HALF_CYC;
          end
        end
        ST_START: begin
          if (rx_cnt_q != 16'h0)
            rx_cnt_q <= rx_cnt_q - 16'h1;
          else if (rx_q)
            rx_st_q <= ST_IDLE;
          else begin
            rx_st_q  <= ST_DATA;
            rx_cnt_q <= BIT_CYC;
            rx_bit_q <= 4'h0;
          end
        end
        ST_DATA: begin
          if (rx_cnt_q != 16'h0)
            rx_cnt_q <= rx_cnt_q - 16'h1;
          else begin
            rx_cnt_q <= BIT_CYC;
            rx_bit_q <= rx_bit_q + 4'h1;
            if (rx_bit_q == 4'h8) begin
              rx_st_q   <= ST_IDLE;
              rx_done_q <= rx_q;
            end else
              rx_sh_q <= {rx_q, rx_sh_q[7:1]};
          end
        end
        default: rx_st_q <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Substitute string buffer and host forwarding
  // ----------------------------------------------------------------
  reg [7:0] fill_mem [0:49];
  reg [7:0] send_mem [0:49];
  reg [5:0] fill_len_q;
  reg [5:0] send_len_q;
  reg [5:0] send_idx_q;
  reg       pend_q;
  reg       busy_q;
  integer   i;
  wire ch_cr   = rx_sh_q == `SRM_CHAR_CR;
  wire ch_ctrl = (rx_sh_q < 8'h20) || (rx_sh_q == 8'h7f);
  wire rx_ok   = rx_done_q && ctrl_q[`SRM_CTRL_SUBST_EN];
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      fill_len_q  <= 6'h0;
      send_len_q  <= 6'h0;
      send_idx_q  <= 6'h0;
      pend_q      <= 1'b0;
      busy_q      <= 1'b0;
      host_valid  <= 1'b0;
      host_data   <= 8'h0;
      host_last   <= 1'b0;
      host_status <= 4'h0;
    end else begin
      if (rx_ok && ch_cr) begin
        if (!busy_q) begin
          for (i = 0; i < `SRM_SUB_MAX; i = i + 1)
            send_mem[i] <= fill_mem[i];
          send_len_q <= fill_len_q;
          pend_q     <= (fill_len_q != 6'h0);
        end
        fill_len_q <= 6'h0;
      end else if (rx_ok && !ch_ctrl && fill_len_q < `SRM_SUB_MAX) begin
        fill_mem[fill_len_q] <= rx_sh_q;
        fill_len_q <= fill_len_q + 6'h1;
      end
      if (pend_q && !busy_q && !read_pulse) begin
        pend_q     <= 1'b0;
        busy_q     <= 1'b1;
        send_idx_q <= 6'h0;
      end
      if (busy_q && (!host_valid || host_ready)) begin
        if (host_valid && host_last) begin
          busy_q     <= 1'b0;
          host_valid <= 1'b0;
          host_last  <= 1'b0;
        end else begin
          host_valid  <= 1'b1;
          host_data   <= send_mem[send_idx_q];
          host_last   <= (send_idx_q + 6'h1 == send_len_q);
          host_status <= ctrl_q[`SRM_CTRL_STAT_EN] ? `SRM_STATUS_SUBST : 4'h0;
          send_idx_q  <= send_idx_q + 6'h1;
        end
      end else if (!busy_q && host_ready)
        host_valid <= 1'b0;
    end
  end
  // ----------------------------------------------------------------
  // Register read
  // ----------------------------------------------------------------
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn)
      reg_rdata <= 32'h0;
    else if (reg_rd) begin
      if (reg_addr == `SRM_REG_CTRL)
        reg_rdata <= {24'h0, ctrl_q};
      else if (reg_addr == `SRM_REG_FUNC)
        reg_rdata <= {20'h0, func_q};
      else if (reg_addr == `SRM_REG_STATUS)
        reg_rdata <= {26'h0, busy_q, pend_q, sw_q, learned_q, learn_q, cmp_en_q};
      else if (reg_addr == `SRM_REG_REF1)
        reg_rdata <= ref1_q;
      else if (reg_addr == `SRM_REG_REF2)
        reg_rdata <= ref2_q;
      else if (reg_addr == `SRM_REG_SUBLEN)
        reg_rdata <= {26'h0, fill_len_q};
      else
        reg_rdata <= 32'h0;
    end
  end
endmodule // srm_scan_result_match

// ### testbench/srm_scan_result_match_asserts.sv
/*
  Checker for the scan result match stage, bound to its top module.
  Assumes the single ref_clk domain and the active-low resetn.
*/
`timescale 1ns/1ps
`include "srm_defines.vh"
module srm_scan_result_match_asserts (
  input wire        ref_clk,
  input wire        resetn,
  input wire [3:0]  reg_addr,
  input wire [31:0] reg_wdata,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [31:0] reg_rdata,
  input wire        teach_sw,
  input wire        code_valid,
  input wire [31:0] code_data,
  input wire        read_pulse,
  input wire        read_interval,
  input wire        nv_write,
  input wire [31:0] nv_data,
  input wire        result1,
  input wire        result2,
  input wire        beeper,
  input wire        term_rxd,
  input wire        host_valid,
  input wire [7:0]  host_data,
  input wire        host_last,
  input wire [3:0]  host_status,
  input wire        host_ready
);
  localparam int PULSE = `SRM_PULSE_CYC;
  logic [15:0] hi_q;

  // A retriggered pulse would read long here; the bench never retriggers.
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) hi_q <= 16'h0000;
    else if (result2) hi_q <= hi_q + 16'h0001;
    else hi_q <= 16'h0000;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  a_learn_opens: assert property ($rose(read_interval) |-> !teach_sw)
    else $error("learn interval opened with switch closed");
  a_learn_read_ends: assert property (read_interval && code_valid |=> ##[0:2] !read_interval)
    else $error("learn read did not end the interval");
  a_store_on_close: assert property ($rose(nv_write) |-> teach_sw)
    else $error("store while switch open");
  a_store_single: assert property (nv_write |=> !nv_write)
    else $error("store pulse longer than one cycle");
  a_pulse_len: assert property ($fell(result2) |-> hi_q == PULSE)
    else $error("result pulse length wrong");
  a_result_cause: assert property ($rose(result1) || $rose(result2) |-> $past(code_valid, 2))
    else $error("result rose without a decoded code");
  a_hold_in_pulse: assert property ($rose(host_valid) |-> !$past(read_pulse))
    else $error("host send started during reading pulse");
  a_host_stall: assert property (host_valid && !host_ready |=> host_valid && $stable(host_data))
    else $error("host byte changed while stalled");
  a_no_control: assert property (host_valid |-> host_data >= 8'h20 && host_data != 8'h7f)
    else $error("control character forwarded");

  cover property (nv_write);
  cover property ($rose(result2));
  cover property (host_valid && host_ready && host_last);
endmodule // srm_scan_result_match_asserts

bind srm_scan_result_match srm_scan_result_match_asserts i_srm_scan_result_match_asserts (
  .ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .teach_sw(teach_sw),
  .code_valid(code_valid), .code_data(code_data), .read_pulse(read_pulse),
  .read_interval(read_interval), .nv_write(nv_write), .nv_data(nv_data),
  .result1(result1), .result2(result2), .beeper(beeper), .term_rxd(term_rxd),
  .host_valid(host_valid), .host_data(host_data), .host_last(host_last),
  .host_status(host_status), .host_ready(host_ready));

// ### testbench/srm_term_model.sv
/*
  Terminal partner: sends characters on an idle-high serial line.
  Assumes ref_clk at the rate the link timing constants expect.
*/
`timescale 1ns/1ps
`include "srm_defines.vh"
module srm_term_model (
  input  wire  ref_clk,
  output logic txd
);
  initial txd = 1'b1;

  // one byte of any value per call, start bit, data LSB first, stop bit; caller ends with CR
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] frame;
    frame = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge ref_clk);
      txd <= frame[i];
      repeat (`SRM_BIT_CYC - 1) @(posedge ref_clk);
    end
  endtask
endmodule // srm_term_model

// ### testbench/srm_scan_result_match_tb.sv
/*
  Self-checking bench for the scan result match stage.
  Assumes the terminal model for the link and a random-stalling host sink.
*/
`timescale 1ns/1ps
`include "srm_defines.vh"
module srm_scan_result_match_tb;
  logic        ref_clk, resetn, reg_wr, reg_rd, teach_sw, code_valid, read_pulse, host_ready;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata, code_data, ref_a, ref_b;
  logic [31:0] rng = 32'he8aa7370;
  wire  [31:0] reg_rdata, nv_data;
  wire         read_interval, nv_write, result1, result2, beeper, term_rxd;
  wire         host_valid, host_last;
  wire  [7:0]  host_data;
  wire  [3:0]  host_status;
  int          fail_count, checks_done;
  logic        rd_seen = 1'b0;
  logic        link_done;
  logic [31:0] rd_q[$], nv_q[$], host_q[$];
  logic [2:0]  fn1 [4] = '{3'h1, 3'h6, 3'h0, 3'h5};
  logic [2:0]  fn2 [4] = '{3'h3, 3'h2, 3'h4, 3'h2};
  logic [1:0]  want [4] = '{2'b01, 2'b01, 2'b11, 2'b10};

  srm_scan_result_match i_srm_scan_result_match (.ref_clk(ref_clk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .teach_sw(teach_sw), .code_valid(code_valid),
    .code_data(code_data), .read_pulse(read_pulse), .read_interval(read_interval),
    .nv_write(nv_write), .nv_data(nv_data), .result1(result1), .result2(result2),
    .beeper(beeper), .term_rxd(term_rxd), .host_valid(host_valid), .host_data(host_data),
    .host_last(host_last), .host_status(host_status), .host_ready(host_ready));
  srm_term_model i_srm_term_model (.ref_clk(ref_clk), .txd(term_rxd));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    reg_rd <= 1'b1; reg_addr <= a; rd_q.push_back(exp);
    @(posedge ref_clk);
    reg_rd <= 1'b0;
  endtask

  task automatic code(input logic [31:0] v);
    @(posedge ref_clk);
    code_valid <= 1'b1; code_data <= v;
    @(posedge ref_clk);
    code_valid <= 1'b0;
  endtask

  task automatic wait_open();
    for (int i = 0; i < 20 && read_interval !== 1'b1; i++) @(posedge ref_clk);
  endtask

  function automatic logic [31:0] xorshift(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    xorshift = y ^ (y << 5);
  endfunction

  // Xorshift source; the host sink stalls at random.
  always @(posedge ref_clk) begin
    rng <= xorshift(rng);
    host_ready <= rng[0];
  end

  // Observer: read data, stored code and host beats against the oldest note.
  always @(posedge ref_clk) begin
    if (rd_seen) check("reg_rdata", reg_rdata, rd_q.pop_front());
    rd_seen <= reg_rd;
    if (nv_write) check("nv_data", nv_data, nv_q.size() ? nv_q.pop_front() : ~nv_data);
    if (host_valid && host_ready)
      check("host beat", {19'h0, host_last, host_status, host_data},
            host_q.size() ? host_q.pop_front() : 32'hffff_ffff);
  end

  initial begin
    // Two link characters take about 104000 cycles; everything else runs beside them.
    repeat (110000) @(posedge ref_clk);
    fail_count++;
    tally_and_finish();
  end

  initial begin
    resetn = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 4'h0; reg_wdata = 32'h0;
    teach_sw = 1'b1; code_valid = 1'b0; code_data = 32'h0; read_pulse = 1'b1;
    link_done = 1'b0;
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    wr(`SRM_REG_CTRL, 32'h0000_001b);
    host_q.push_back({19'h0, 1'b1, `SRM_STATUS_SUBST, 8'h41});
    fork
      begin
        i_srm_term_model.send_byte(8'h41);
        i_srm_term_model.send_byte(`SRM_CHAR_CR);
        link_done = 1'b1;
      end
    join_none
    repeat (20) @(posedge ref_clk);
    rd(`SRM_REG_STATUS, 32'h0000_0009);
    rd(`SRM_REG_FUNC, {20'h0, `SRM_FUNC_RESET});
    rd(4'hf, 32'h0);
    rd(`SRM_REG_CTRL, 32'h0000_001b);
    ref_a = rng;
    ref_b = ~rng;
    teach_sw <= 1'b0;
    wait_open();
    check("read_interval", {31'h0, read_interval}, 32'h1);
    code(ref_a);
    repeat (3) @(posedge ref_clk);
    check("read_interval", {31'h0, read_interval}, 32'h0);
    nv_q.push_back(ref_a);
    teach_sw <= 1'b1;
    repeat (10) @(posedge ref_clk);
    rd(`SRM_REG_REF1, ref_a);
    teach_sw <= 1'b0;
    wait_open();
    check("read_interval", {31'h0, read_interval}, 32'h1);
    teach_sw <= 1'b1;
    repeat (10) @(posedge ref_clk);
    check("read_interval", {31'h0, read_interval}, 32'h0);
    rd(`SRM_REG_REF1, ref_a);
    wr(`SRM_REG_REF2, ref_a);
    // Second reference stays off in the first round only.
    for (int i = 0; i < 4; i++) begin
      wr(`SRM_REG_CTRL, i == 0 ? 32'h0000_001b : 32'h0000_001f);
      wr(`SRM_REG_FUNC, {25'h0, fn2[i], 1'b0, fn1[i]});
      code(i < 2 ? ref_a : ref_b);
      repeat (3) @(posedge ref_clk);
      check("result pair", {30'h0, result2, result1}, {30'h0, want[i]});
      repeat (10010) @(posedge ref_clk);
    end
    // Reading mode entry: tone, gap, tone, then quiet, each 20000 cycles.
    wr(`SRM_REG_CTRL, 32'h0000_005b);
    repeat (10000) @(posedge ref_clk);
    check("beeper", {31'h0, beeper}, 32'h1);
    repeat (20000) @(posedge ref_clk);
    check("beeper", {31'h0, beeper}, 32'h0);
    repeat (20000) @(posedge ref_clk);
    check("beeper", {31'h0, beeper}, 32'h1);
    repeat (11000) @(posedge ref_clk);
    check("beeper", {31'h0, beeper}, 32'h0);
    while (!link_done) @(posedge ref_clk);
    repeat (10) @(posedge ref_clk);
    read_pulse <= 1'b0;
    for (int i = 0; i < 400 && host_q.size() > 0; i++) @(posedge ref_clk);
    check("host queue left", host_q.size(), 32'h0);
    wr(`SRM_REG_CTRL, 32'h0000_003b);
    rd(`SRM_REG_CTRL, 32'h0000_0013);
    repeat (2) @(posedge ref_clk);
    tally_and_finish();
  end
endmodule // srm_scan_result_match_tb
